// ===== rtl/sfio_map.svh
// Constants for the serial to parallel frame controller.
`ifndef SFIO_MAP_SVH
`define SFIO_MAP_SVH

// Message layout, shared by messages and replies.
`define SFIO_MSG_W 21
`define SFIO_LATCH_W 19
`define SFIO_DATA_W 16
`define SFIO_START_HI 20
`define SFIO_START_LO 18
`define SFIO_PAR_HI 17
`define SFIO_PAR_LO 16

// Start codes and parity sense.
`define SFIO_START_NORM 3'h6
`define SFIO_START_MAINT 3'h5
`define SFIO_PAR_ODD 1'h1

// Subchannels and peripherals.
`define SFIO_NUM_SUB 4
`define SFIO_NUM_PER 3

// Link bit rate in kilobits per second.
`define SFIO_BIT_KBPS 6670

// Idle timeout: least time, rounded up to whole cycles.
`define SFIO_IDLE_NS 1000
`define SFIO_CLK_NS 10
`define SFIO_IDLE_CYC ((`SFIO_IDLE_NS + `SFIO_CLK_NS - 1) / `SFIO_CLK_NS)

`endif

// ===== rtl/sfio_pkg.sv
// Types for the serial to parallel frame controller.
package sfio_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PURGE = 3'h1,
      ST_RECV = 3'h2,
      ST_XFER = 3'h3,
      ST_GO = 3'h4,
      ST_XMIT = 3'h5,
      ST_DONE = 3'h6
   } sfio_state_type;
endpackage : sfio_pkg

// ===== rtl/sfio_link_front.sv
// Link-clock front end: bit capture and reply lobe driver.
`timescale 1ns/100ps
`include "sfio_map.svh"
module sfio_link_front (
   // Link clock and system reset.
   input wire logic linkClk,
   input wire logic reset,
   // Inbound lobes, one pair per subchannel.
   input wire logic [3:0] rxPos,
   input wire logic [3:0] rxNeg,
   // Outbound reply lobes.
   output logic txPos,
   output logic txNeg,
   // Captured bit towards the system clock.
   output logic bitTgl,
   output logic bitVal,
   output logic [1:0] bitSub,
   // Reply bit from the system clock.
   input wire logic txEn,
   input wire logic txBit
);
   logic rstS1;
   logic rstS2;
   logic txEnS1;
   logic txEnS2;
   logic txBitS1;
   logic txBitS2;
   logic [3:0] lobe;
   logic hit;

   // Returns the index of the active subchannel.
   function automatic logic [1:0] subOf(input logic [3:0] l);
      logic [1:0] s;
      s = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (l[i]) begin
            s = 2'(i);
         end
      end
      return s;
   endfunction : subOf

   assign lobe = rxPos | rxNeg;
   assign hit = |lobe;

   // Brings reset and the reply levels onto the link clock.
   always_ff @(posedge linkClk) begin
      rstS1 <= reset;
      rstS2 <= rstS1;
      txEnS1 <= txEn;
      txEnS2 <= txEnS1;
      txBitS1 <= txBit;
      txBitS2 <= txBitS1;
   end

   // subchannel capture.
   // Each lobe is one bit; a positive lobe is a one, a negative one a zero.
   always_ff @(posedge linkClk) begin
      if (rstS2) begin
         bitTgl <= 1'h0;
         bitVal <= 1'h0;
         bitSub <= 2'h0;
      end else if (hit) begin
         bitTgl <= ~bitTgl;
         bitVal <= |rxPos;
         bitSub <= subOf(lobe);
      end
   end

   // clocked by inbound.
   // A reply bit leaves only when an inbound bit arrives.
   always_ff @(posedge linkClk) begin
      if (rstS2) begin
         txPos <= 1'h0;
         txNeg <= 1'h0;
      end else begin
         txPos <= hit && txEnS2 && txBitS2;
         txNeg <= hit && txEnS2 && !txBitS2;
      end
   end
endmodule : sfio_link_front

// ===== rtl/sfio_frame_io_controller.sv
// Frame controller bridging the serial link to the peripheral bus.
// Function
// - Four inbound subchannels, one reply link; subchannel picks the peripheral.
// - Subchannels 0 and 3 scanner, 1 pulse distributor, 2 network.
// - Both link directions carry bipolar pulses at 6.67 Mb/s.
// - The leading one bit arms the receiver for the message.
// - On arrival record subchannel and enter receive or purge.
// - Accept the message only if the shift register was all zeros.
// - Shift register loads serially, or takes the reply in parallel.
// - When fully loaded, stop the shift pulses.
// - Latch the message only after start code and, for start 110, parity pass.
// - Latch drives the bus and holds until new data is latched.
// - Accept enable goes only to the addressed peripheral.
// - Selector loads only the addressed peripheral's reply.
// - Reply is 16 data bits, 2 parity bits, 3-bit start code.
// - After loading, the transmitter sends the reply as bipolar pulses.
// - Reply bits are timed by inbound zeros, not a local clock.
// - Replies use the same layout as messages.
// - When the stream stops, return to idle.
// - Accept start 110 with good parity, or 101 with any parity.
// - Purge ignores the message and fills the register with zeros.
// - Idle after about one microsecond without pulses.
`timescale 1ns/100ps
`include "sfio_map.svh"
module sfio_frame_io_controller
   import sfio_pkg::*;
#(
   parameter int IDLE_CYC = `SFIO_IDLE_CYC
) (
   // System clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Link clock and inbound lobes from central_control.
   input wire logic linkClk,
   input wire logic [3:0] rxPos,
   input wire logic [3:0] rxNeg,
   // Reply lobes to central_control.
   output logic txPos,
   output logic txNeg,
   // Shared parallel data bus.
   output logic [18:0] dataBus,
   // Peripheral accept and selector enables, scanner bit 0.
   output logic [2:0] acceptEn,
   output logic [2:0] selectEn,
   // Peripheral replies.
   input wire logic [2:0] replyEn,
   input wire logic [47:0] replyData,
   // Receiver idle status.
   output logic idle
);
   sfio_state_type stateFf;
   logic [20:0] shiftFf;
   logic [18:0] latchFf;
   logic [1:0] subFf;
   logic [15:0] idleCntFf;
   logic idleFf;
   logic [4:0] txCntFf;
   logic txEnFf;
   logic txArmFf;
   logic txBitFf;
   logic tglS1;
   logic tglS2;
   logic tglS3;
   logic bitTgl;
   logic bitVal;
   logic [1:0] bitSub;
   logic bitEvt;
   logic [1:0] tgt;
   logic [15:0] selData;
   logic [2:0] startCode;
   logic parOk;
   logic msgOk;
   logic stopShift;
   logic loadRep;

   // Parity bit for one data byte in the chosen sense.
   function automatic logic parOf(input logic [7:0] d);
      return `SFIO_PAR_ODD ? ~(^d) : (^d);
   endfunction : parOf

   // Maps a subchannel to its peripheral index.
   function automatic logic [1:0] tgtOf(input logic [1:0] s);
      logic [1:0] t;
      t = 2'h0;
      case (s)
         2'h1: t = 2'h1;
         2'h2: t = 2'h2;
         default: t = 2'h0;
      endcase
      return t;
   endfunction : tgtOf

   // Front end running on the link clock.
   sfio_link_front u_front (
      .linkClk(linkClk),
      .reset(reset),
      .rxPos(rxPos),
      .rxNeg(rxNeg),
      .txPos(txPos),
      .txNeg(txNeg),
      .bitTgl(bitTgl),
      .bitVal(bitVal),
      .bitSub(bitSub),
      .txEn(txEnFf),
      .txBit(txBitFf)
   );

   // Toggle synchroniser; bit value and subchannel are stable by then.
   always_ff @(posedge clk) begin
      if (reset) begin
         tglS1 <= 1'h0;
         tglS2 <= 1'h0;
         tglS3 <= 1'h0;
      end else begin
         tglS1 <= bitTgl;
         tglS2 <= tglS1;
         tglS3 <= tglS2;
      end
   end

   assign bitEvt = tglS2 ^ tglS3;

   assign tgt = tgtOf(subFf);

   always_comb begin
      case (tgt)
         2'h1: selData = replyData[31:16];
         2'h2: selData = replyData[47:32];
         default: selData = replyData[15:0];
      endcase
   end

   assign startCode = shiftFf[`SFIO_START_HI:`SFIO_START_LO];
   assign parOk = (shiftFf[`SFIO_PAR_HI] == parOf(shiftFf[15:8]))
      && (shiftFf[`SFIO_PAR_LO] == parOf(shiftFf[7:0]));
   assign msgOk = ((startCode == `SFIO_START_NORM) && parOk)
      || (startCode == `SFIO_START_MAINT);

   // shift inhibit.
   // The first inbound bit of a reply only arms the sender, so that shifts
   // and lobes stay two link edges apart, whatever the load phase.
   assign stopShift = (stateFf == ST_XFER) || (stateFf == ST_GO)
      || ((stateFf == ST_RECV) && shiftFf[20])
      || ((stateFf == ST_XMIT) && !txArmFf);

   assign loadRep = (stateFf == ST_GO) && replyEn[tgt];

   assign acceptEn = (stateFf == ST_GO) ? (3'h1 << tgt) : 3'h0;
   assign selectEn = (stateFf == ST_GO) ? (3'h1 << tgt) : 3'h0;
   assign dataBus = latchFf;
   assign idle = idleFf;

   always_ff @(posedge clk) begin
      if (reset) begin
         idleCntFf <= 16'h0;
         idleFf <= 1'h1;
      end else if (bitEvt) begin
         idleCntFf <= 16'h0;
         idleFf <= 1'h0;
      end else if (idleCntFf == 16'(IDLE_CYC - 1)) begin
         idleFf <= 1'h1;
      end else begin
         idleCntFf <= idleCntFf + 16'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         stateFf <= ST_IDLE;
         subFf <= 2'h0;
      end else if (idleFf && !bitEvt && stateFf != ST_IDLE) begin
         stateFf <= ST_IDLE;
      end else begin
         case (stateFf)
            ST_IDLE: begin
               if (bitEvt && bitVal) begin
                  subFf <= bitSub;
                  stateFf <= (shiftFf == 21'h0) ? ST_RECV : ST_PURGE;
               end
            end
            ST_RECV: begin
               if (shiftFf[20]) begin
                  stateFf <= ST_XFER;
               end
            end
            ST_XFER: begin
               if (msgOk) begin
                  stateFf <= ST_GO;
               end
            end
            ST_GO: begin
               if (loadRep) begin
                  stateFf <= ST_XMIT;
               end
            end
            ST_XMIT: begin
               if (bitEvt && txArmFf && txCntFf == 5'(`SFIO_MSG_W - 1)) begin
                  stateFf <= ST_DONE;
               end
            end
            default: begin
               stateFf <= stateFf;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         shiftFf <= 21'h0;
      end else if (loadRep) begin
         shiftFf <= {`SFIO_START_NORM, parOf(selData[15:8]), parOf(selData[7:0]), selData};
      end else if (bitEvt && !stopShift && (stateFf != ST_IDLE || bitVal)) begin
         shiftFf <= {shiftFf[19:0], bitVal};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         latchFf <= 19'h0;
      end else if (stateFf == ST_XFER && msgOk) begin
         latchFf <= shiftFf[`SFIO_LATCH_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         txCntFf <= 5'h0;
         txEnFf <= 1'h0;
         txArmFf <= 1'h0;
         txBitFf <= 1'h0;
      end else begin
         txEnFf <= (stateFf == ST_XMIT) && txArmFf;
         txBitFf <= shiftFf[20];
         if (loadRep) begin
            txCntFf <= 5'h0;
            txArmFf <= 1'h0;
         end else if (bitEvt && stateFf == ST_XMIT) begin
            txArmFf <= 1'h1;
            if (txArmFf) begin
               txCntFf <= txCntFf + 5'h1;
            end
         end
      end
   end

   property p_map;
      @(posedge clk) disable iff (reset)
      (stateFf == ST_GO && subFf == 2'h3) |-> acceptEn == 3'h1;
   endproperty
   a_map: assert property (p_map) else $error("Subchannel 3 not to scanner.");

   property p_purge;
      @(posedge clk) disable iff (reset)
      (stateFf == ST_IDLE && bitEvt && bitVal && shiftFf != 21'h0) |=> stateFf == ST_PURGE;
   endproperty
   a_purge: assert property (p_purge) else $error("Dirty register did not purge.");

   property p_recv;
      @(posedge clk) disable iff (reset)
      (stateFf == ST_IDLE && bitEvt && bitVal && shiftFf == 21'h0)
         |=> stateFf == ST_RECV && subFf == $past(bitSub) && shiftFf == 21'h1;
   endproperty
   a_recv: assert property (p_recv) else $error("Receive entry wrong.");

   property p_stop;
      @(posedge clk) disable iff (reset)
      (stateFf == ST_XFER) |=> $stable(shiftFf);
   endproperty
   a_stop: assert property (p_stop) else $error("Shift during transfer.");

   property p_bad;
      @(posedge clk) disable iff (reset)
      (stateFf == ST_XFER && !msgOk && !idleFf) |=> stateFf == ST_XFER && $stable(dataBus);
   endproperty
   a_bad: assert property (p_bad) else $error("Bad message left transfer.");

   property p_hold;
      @(posedge clk) disable iff (reset)
      (stateFf != ST_XFER) |=> $stable(dataBus);
   endproperty
   a_hold: assert property (p_hold) else $error("Bus changed outside transfer.");

   property p_enable;
      @(posedge clk) disable iff (reset)
      (acceptEn != 3'h0) |-> stateFf == ST_GO && $onehot(acceptEn) && selectEn == acceptEn;
   endproperty
   a_enable: assert property (p_enable) else $error("Enable not one-hot in go.");

   property p_load;
      @(posedge clk) disable iff (reset)
      loadRep |=> stateFf == ST_XMIT && shiftFf[20:18] == `SFIO_START_NORM
         && shiftFf[15:0] == $past(selData);
   endproperty
   a_load: assert property (p_load) else $error("Reply load wrong.");

   property p_rpar;
      @(posedge clk) disable iff (reset)
      loadRep |=> shiftFf[17] == parOf(shiftFf[15:8]) && shiftFf[16] == parOf(shiftFf[7:0]);
   endproperty
   a_rpar: assert property (p_rpar) else $error("Reply parity wrong.");

   property p_idle;
      @(posedge clk) disable iff (reset)
      $rose(idleFf) |-> $past(idleCntFf) == 16'(IDLE_CYC - 1) && !$past(bitEvt);
   endproperty
   a_idle: assert property (p_idle) else $error("Idle timing wrong.");

   property p_back;
      @(posedge clk) disable iff (reset)
      (idleFf && !bitEvt) |=> stateFf == ST_IDLE;
   endproperty
   a_back: assert property (p_back) else $error("No return to idle.");
endmodule : sfio_frame_io_controller

// ===== sim/sfio_cc_model.sv
// Central control model: sends framed messages and collects the replies.
`timescale 1ns/100ps
module sfio_cc_model (
   // Reset keeps the link clock running.
   input wire logic reset,
   // Link clock and inbound lobes.
   output logic linkClk,
   output logic [3:0] rxPos,
   output logic [3:0] rxNeg,
   // Reply lobes.
   input wire logic txPos,
   input wire logic txNeg
);
   logic linkRun;
   logic [20:0] reply;
   int replyCount;

   // Link clock of 160 ns, standing still outside frames and reset.
   initial begin
      linkClk = 1'b0;
      linkRun = 1'b0;
      rxPos = 4'h0;
      rxNeg = 4'h0;
      #3.3;
      forever begin
         #80;
         if (linkRun || reset || linkClk) begin
            linkClk = ~linkClk;
         end
      end
   end

   always @(negedge linkClk) begin
      if (txPos || txNeg) begin
         reply <= {reply[19:0], txPos};
         replyCount <= replyCount + 1;
      end
   end

   task automatic send(input int sub, input logic [20:0] msg);
      int i;
      replyCount = 0;
      linkRun = 1'b1;
      // Quiet edges let the link side leave reset before the first bit.
      repeat (4) @(posedge linkClk);
      for (i = 0; i < 21; i++) begin
         @(posedge linkClk);
         #1;
         rxPos = 4'(msg[20 - i]) << sub;
         rxNeg = 4'(!msg[20 - i]) << sub;
      end
      for (i = 0; i < 70 && replyCount < 21; i++) begin
         @(posedge linkClk);
         #1;
         rxPos = 4'h0;
         rxNeg = 4'h1 << sub;
      end
      @(posedge linkClk);
      #1;
      rxPos = 4'h0;
      rxNeg = 4'h0;
      repeat (3) @(posedge linkClk);
      linkRun = 1'b0;
   endtask : send
endmodule : sfio_cc_model

// ===== sim/test_sfio_frame_io_controller.sv
// Testbench for the frame controller with link and peripheral models.
`timescale 1ns/100ps
`define CHECK(got, exp) begin checkCount++; if ((got) !== (exp)) begin badCount++; \
   $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module test_sfio_frame_io_controller
   import sfio_pkg::*;
;
   localparam int IDLE_CYC = 20;
   logic clk, reset, linkClk, txPos, txNeg, idle, frameDone;
   logic [3:0] rxPos, rxNeg;
   logic [18:0] dataBus, lastBus;
   logic [2:0] acceptEn, selectEn, replyEn;
   logic [47:0] replyData;
   logic [31:0] lfsr;
   int badCount, checkCount;

   // System clock of 10 ns.
   always #5 clk = ~clk;

   sfio_frame_io_controller #(.IDLE_CYC(IDLE_CYC)) sfio_frame_io_controller_i (.clk(clk),
      .reset(reset), .linkClk(linkClk), .rxPos(rxPos), .rxNeg(rxNeg), .txPos(txPos),
      .txNeg(txNeg), .dataBus(dataBus), .acceptEn(acceptEn), .selectEn(selectEn),
      .replyEn(replyEn), .replyData(replyData), .idle(idle));
   sfio_cc_model sfio_cc_model_i (.reset(reset), .linkClk(linkClk), .rxPos(rxPos),
      .rxNeg(rxNeg), .txPos(txPos), .txNeg(txNeg));

   // Pseudo-random source from a shift register.
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
      return lfsr;
   endfunction : rnd

   // Prints the verdict and ends the run.
   task automatic giveVerdict();
      if (badCount == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : giveVerdict

   // Counts a wait that ran out and closes the run.
   task automatic timeout();
      badCount++;
      $display("Error at %0t: wait limit reached", $time);
      giveVerdict();
   endtask : timeout

   // Builds a message with odd parity, or a wrong high parity bit.
   function automatic logic [20:0] mkMsg(input logic [2:0] code, input logic [15:0] d,
      input logic good);
      return {code, (~^d[15:8]) ^ !good, ~^d[7:0], d};
   endfunction : mkMsg

   // One exchange: message on a subchannel, peripheral reply, then idle.
   task automatic doFrame(input int sub, input logic [20:0] msg, input logic expAcc);
      logic [2:0] oneHot;
      logic [31:0] r1, r2;
      logic [15:0] rdSel;
      logic [20:0] expRep;
      logic seen;
      int i, idx;
      idx = (sub == 3) ? 0 : sub;
      oneHot = 3'h1 << idx;
      seen = 1'b0;
      rdSel = 16'h0;
      frameDone = 1'b0;
      fork
         begin
            sfio_cc_model_i.send(sub, msg);
            frameDone = 1'b1;
         end
         begin
            for (i = 0; i < 4000 && acceptEn === 3'h0 && !frameDone; i++) begin
               @(posedge clk);
            end
            if (acceptEn !== 3'h0) begin
               seen = 1'b1;
               `CHECK(acceptEn, oneHot)
               `CHECK(selectEn, oneHot)
               `CHECK(dataBus, msg[18:0])
               `CHECK(idle, 1'b0)
               r1 = rnd();
               r2 = rnd();
               rdSel = ({r1[15:0], r2} >> (16 * idx));
               repeat (r1[19:16]) @(posedge clk);
               #1;
               replyData = {r1[15:0], r2};
               replyEn = 3'h7;
               for (i = 0; i < 200 && acceptEn !== 3'h0; i++) begin
                  @(posedge clk);
               end
               #1;
               replyEn = 3'h0;
               if (acceptEn !== 3'h0) begin
                  timeout();
               end
               `CHECK(dataBus, msg[18:0])
            end
         end
      join
      if (expAcc) begin
         expRep = {3'h6, ~^rdSel[15:8], ~^rdSel[7:0], rdSel};
         `CHECK(seen, 1'b1)
         `CHECK(sfio_cc_model_i.replyCount, 21)
         `CHECK(sfio_cc_model_i.reply, expRep)
         lastBus = msg[18:0];
      end else begin
         `CHECK(seen, 1'b0)
         `CHECK(sfio_cc_model_i.replyCount, 0)
         `CHECK(dataBus, lastBus)
      end
      for (i = 0; i < IDLE_CYC + 300 && idle !== 1'b1; i++) begin
         @(posedge clk);
      end
      `CHECK(idle, 1'b1)
      if (idle !== 1'b1) begin
         timeout();
      end
   endtask : doFrame

   // Main sequence: reset, each subchannel, start codes 4 to 7, purge and retry.
   initial begin
      logic [31:0] d;
      logic [20:0] m;
      int s, c;
      clk = 1'b0;
      reset = 1'b1;
      replyEn = 3'h0;
      replyData = 48'h0;
      lfsr = 32'hDAB8;
      badCount = 0;
      checkCount = 0;
      lastBus = 19'h0;
      frameDone = 1'b0;
      // Reset is held twelve cycles; the link side applies it on its first frame edges.
      repeat (12) @(posedge clk);
      #1;
      reset = 1'b0;
      `CHECK(dataBus, 19'h0)
      `CHECK(acceptEn, 3'h0)
      for (s = 0; s < 4; s++) begin
         d = rnd();
         doFrame(s, mkMsg(3'h6, d[15:0], 1'b1), 1'b1);
      end
      for (c = 4; c < 8; c++) begin
         d = rnd();
         m = mkMsg(c[2:0], d[15:0], 1'b0);
         doFrame(int'(d[17:16]), m, c == 5);
         if (c != 5) begin
            doFrame(int'(d[17:16]), m, 1'b0);
         end
      end
      d = rnd();
      doFrame(3, mkMsg(3'h6, d[15:0], 1'b1), 1'b1);
      giveVerdict();
   end

   // Watchdog against a hung run.
   initial begin
      #400000;
      timeout();
   end
endmodule : test_sfio_frame_io_controller
